// file: core/rics_regs.vh
/*
  constants for the reset, initialisation and configuration store block.
  assumes a 40 MHz sys_clk; included by its bare name from the core files.
*/
`ifndef RICS_REGS_VH
`define RICS_REGS_VH

// clock and times
`define RICS_CLK_HZ 40000000
`define RICS_INIT_TIME_MS 20
// 20 ms at 40 MHz, sized to the init counter
`define RICS_INIT_CYC 20'hC_3500
`define RICS_RELEASE_TIME_MS 1
`define RICS_RELEASE_CYC (`RICS_CLK_HZ / 1000 * `RICS_RELEASE_TIME_MS)
`define RICS_CNT_W 20

// configuration store geometry
`define RICS_ADDR_W 4
`define RICS_DATA_W 18
`define RICS_DEPTH 16
`define RICS_LAST_ADDR 4'hF
`define RICS_FAST_PINS 8
`define RICS_GPIO_PINS 18

// configuration word addresses
`define RICS_CFG_GPIO_OE 4'h0
`define RICS_CFG_GPIO_OUT 4'h1
`define RICS_CFG_CTRL 4'h2
`define RICS_CFG_FAST_OUT 4'h3
`define RICS_CTRL_SEQ_BIT 0
`define RICS_CTRL_FAULT_BIT 1

// factory default word (erased store)
`define RICS_FACTORY_WORD 18'h0_0000

// sequencer states
`define RICS_ST_RESET 3'h0
`define RICS_ST_LOAD 3'h1
`define RICS_ST_WAIT 3'h2
`define RICS_ST_RUN 3'h3
`define RICS_ST_STORE 3'h4

`endif

// file: core/rics_cfg_mem.v
/*
  small configuration memory: one write port, one registered read port.
  assumes a single clock; contents start at the factory default word.
*/
`timescale 1ns/100ps
`include "rics_regs.vh"
module rics_cfg_mem (
  input wire sys_clk,
  input wire wrEn,
  input wire [`RICS_ADDR_W-1:0] wrAddr,
  input wire [`RICS_DATA_W-1:0] wrData,
  input wire [`RICS_ADDR_W-1:0] rdAddr,
  output reg [`RICS_DATA_W-1:0] rdData
);
  // storage array, not reset: it must survive a device reset
  reg [`RICS_DATA_W-1:0] memArr [0:`RICS_DEPTH-1];
  integer i;

  // factory contents
  initial begin
    for (i = 0; i < `RICS_DEPTH; i = i + 1) begin
      memArr[i] = `RICS_FACTORY_WORD;
    end
  end

  // write port and registered read port
  always @(posedge sys_clk) begin
    if (wrEn) begin
      memArr[wrAddr] <= wrData;
    end
    rdData <= memArr[rdAddr];
  end
endmodule

// file: core/rics_reset_init.v
/*
  reset control, initialisation phase and configuration store of the
  power sequencer: supply detector and reset pin are synchronised, an
  initialisation phase loads flash into working RAM and drives the pins
  to safe states, then the stored configuration steers pins and modes.
  assumes supplyOk from an analogue detector and extResetN from a pin,
  both asynchronous; host write and store strobes come on sys_clk.
*/
`timescale 1ns/100ps
`include "rics_regs.vh"
module rics_reset_init #(
  parameter [`RICS_CNT_W-1:0] INIT_CYC = `RICS_INIT_CYC
) (
  input wire sys_clk,
  input wire rst,
  input wire supplyOk,
  input wire extResetN,
  input wire cfgWrEn,
  input wire [`RICS_ADDR_W-1:0] cfgWrAddr,
  input wire [`RICS_DATA_W-1:0] cfgWrData,
  output wire cfgWrReady,
  input wire storeAllReq,
  output wire storeAllReady,
  output reg storeDone_r,
  output reg inReset_r,
  output reg initActive_r,
  output reg normalRun_r,
  output reg [`RICS_FAST_PINS-1:0] fastPulseOut_r,
  output reg [`RICS_FAST_PINS-1:0] fastPulseOe_r,
  output reg [`RICS_GPIO_PINS-1:0] gpioOut_r,
  output reg [`RICS_GPIO_PINS-1:0] gpioOe_r,
  output reg seqEnable_r,
  output reg faultRespEnable_r
);
  // synchroniser stages; first stage feeds only the second
  reg supplyMeta_r;
  reg supplySync_r;
  reg extMeta_r;
  reg extSync_r;
  // sequencer state
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`RICS_CNT_W-1:0] initCnt_r;
  reg [`RICS_ADDR_W-1:0] cpyIdx_r;
  reg cpyPhase_r;
  reg loadDone_r;
  // shadow configuration captured from working RAM writes
  reg [`RICS_DATA_W-1:0] shGpioOe_r;
  reg [`RICS_DATA_W-1:0] shGpioOut_r;
  reg [`RICS_DATA_W-1:0] shCtrl_r;
  reg [`RICS_DATA_W-1:0] shFast_r;
  // memory ports
  wire [`RICS_DATA_W-1:0] ramRdData;
  wire [`RICS_DATA_W-1:0] flashRdData;
  reg ramWrEn;
  reg [`RICS_ADDR_W-1:0] ramWrAddr;
  reg [`RICS_DATA_W-1:0] ramWrData;
  wire flashWrEn;
  wire internalReset;
  wire hostWrite;
  wire cpyLast;
  // unit steps sized to their counters, and the last init cycle
  localparam [`RICS_CNT_W-1:0] CNT_ONE = {{(`RICS_CNT_W-1){1'b0}}, 1'b1};
  localparam [`RICS_ADDR_W-1:0] IDX_ONE = {{(`RICS_ADDR_W-1){1'b0}}, 1'b1};
  localparam [`RICS_CNT_W-1:0] INIT_LAST = INIT_CYC - CNT_ONE;

  // two flops on each asynchronous input before any logic reads it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      supplyMeta_r <= 1'b0;
      supplySync_r <= 1'b0;
      extMeta_r <= 1'b0;
      extSync_r <= 1'b0;
    end else begin
      supplyMeta_r <= supplyOk;
      supplySync_r <= supplyMeta_r;
      extMeta_r <= extResetN;
      extSync_r <= extMeta_r;
    end
  end

  // reset held while supply low or pin low; release is a clean edge
  assign internalReset = ~supplySync_r | ~extSync_r;

  // host strobes are taken only in the run state, not during a store
  assign cfgWrReady = (state_r == `RICS_ST_RUN);
  assign storeAllReady = (state_r == `RICS_ST_RUN);
  assign hostWrite = cfgWrEn & cfgWrReady;
  assign cpyLast = (cpyIdx_r == `RICS_LAST_ADDR);

  // working RAM write source: flash load during init, else the host
  always @* begin
    ramWrEn = 1'b0;
    ramWrAddr = cpyIdx_r;
    ramWrData = flashRdData;
    if (state_r == `RICS_ST_LOAD) begin
      ramWrEn = cpyPhase_r;
    end else if (hostWrite) begin
      // a parameter write lands in RAM only
      ramWrEn = 1'b1;
      ramWrAddr = cfgWrAddr;
      ramWrData = cfgWrData;
    end
  end

  // flash written only by the store-all copy
  assign flashWrEn = (state_r == `RICS_ST_STORE) & cpyPhase_r;

  // next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `RICS_ST_RESET: begin
        // leaves on the first edge after synced release, far inside 1 ms
        if (!internalReset) state_nxt = `RICS_ST_LOAD;
      end
      `RICS_ST_LOAD: begin
        if (cpyPhase_r && cpyLast) state_nxt = `RICS_ST_WAIT;
      end
      `RICS_ST_WAIT: begin
        if (initCnt_r == INIT_LAST) state_nxt = `RICS_ST_RUN;
      end
      `RICS_ST_RUN: begin
        if (storeAllReq) state_nxt = `RICS_ST_STORE;
      end
      `RICS_ST_STORE: begin
        if (cpyPhase_r && cpyLast) state_nxt = `RICS_ST_RUN;
      end
      default: begin
        state_nxt = `RICS_ST_RESET;
      end
    endcase
    // reset detector overrides everything
    if (internalReset) state_nxt = `RICS_ST_RESET;
  end

  // state, counters and copy walker
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= `RICS_ST_RESET;
      initCnt_r <= {`RICS_CNT_W{1'b0}};
      cpyIdx_r <= {`RICS_ADDR_W{1'b0}};
      cpyPhase_r <= 1'b0;
      loadDone_r <= 1'b0;
      storeDone_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      storeDone_r <= (state_r == `RICS_ST_STORE) & (state_nxt == `RICS_ST_RUN);
      // init count starts with the first cycle out of reset
      if (state_r == `RICS_ST_LOAD || state_r == `RICS_ST_WAIT) begin
        initCnt_r <= initCnt_r + CNT_ONE;
      end else begin
        initCnt_r <= {`RICS_CNT_W{1'b0}};
      end
      // phase 0 addresses the source, phase 1 writes the target
      if (state_r == `RICS_ST_LOAD || state_r == `RICS_ST_STORE) begin
        cpyPhase_r <= ~cpyPhase_r;
        if (cpyPhase_r) cpyIdx_r <= cpyIdx_r + IDX_ONE;
      end else begin
        cpyPhase_r <= 1'b0;
        cpyIdx_r <= {`RICS_ADDR_W{1'b0}};
      end
      loadDone_r <= (state_r == `RICS_ST_WAIT) | (state_r == `RICS_ST_RUN) |
        (state_r == `RICS_ST_STORE);
    end
  end

  // shadow copy of the live configuration words
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shGpioOe_r <= `RICS_FACTORY_WORD;
      shGpioOut_r <= `RICS_FACTORY_WORD;
      shCtrl_r <= `RICS_FACTORY_WORD;
      shFast_r <= `RICS_FACTORY_WORD;
    end else if (ramWrEn) begin
      // track the four config words (addresses 0..3) as they land in working RAM
      case (ramWrAddr)
        `RICS_CFG_GPIO_OE: shGpioOe_r <= ramWrData;
        `RICS_CFG_GPIO_OUT: shGpioOut_r <= ramWrData;
        `RICS_CFG_CTRL: shCtrl_r <= ramWrData;
        `RICS_CFG_FAST_OUT: shFast_r <= ramWrData;
        default: begin
          shCtrl_r <= shCtrl_r;
        end
      endcase
    end
  end

  // pins and status: safe states until normal run, config afterwards
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inReset_r <= 1'b1;
      initActive_r <= 1'b0;
      normalRun_r <= 1'b0;
      fastPulseOut_r <= {`RICS_FAST_PINS{1'b0}};
      fastPulseOe_r <= {`RICS_FAST_PINS{1'b1}};
      gpioOut_r <= {`RICS_GPIO_PINS{1'b0}};
      gpioOe_r <= {`RICS_GPIO_PINS{1'b0}};
      seqEnable_r <= 1'b0;
      faultRespEnable_r <= 1'b0;
    end else begin
      inReset_r <= (state_nxt == `RICS_ST_RESET);
      initActive_r <= (state_nxt == `RICS_ST_LOAD) | (state_nxt == `RICS_ST_WAIT);
      normalRun_r <= (state_nxt == `RICS_ST_RUN) | (state_nxt == `RICS_ST_STORE);
      // fast pins always driven: low until run, then configured value
      fastPulseOe_r <= {`RICS_FAST_PINS{1'b1}};
      if ((state_nxt == `RICS_ST_RUN || state_nxt == `RICS_ST_STORE) && loadDone_r) begin
        // run from configuration; factory words give hi-Z GPIO, fast pins low and no modes
        fastPulseOut_r <= shFast_r[`RICS_FAST_PINS-1:0];
        gpioOe_r <= shGpioOe_r[`RICS_GPIO_PINS-1:0];
        gpioOut_r <= shGpioOut_r[`RICS_GPIO_PINS-1:0];
        seqEnable_r <= shCtrl_r[`RICS_CTRL_SEQ_BIT];
        faultRespEnable_r <= shCtrl_r[`RICS_CTRL_FAULT_BIT];
      end else begin
        // reset and init: fast pins low, all others open
        fastPulseOut_r <= {`RICS_FAST_PINS{1'b0}};
        gpioOe_r <= {`RICS_GPIO_PINS{1'b0}};
        gpioOut_r <= {`RICS_GPIO_PINS{1'b0}};
        seqEnable_r <= 1'b0;
        faultRespEnable_r <= 1'b0;
      end
    end
  end

  // working RAM
  rics_cfg_mem uRam (
    .sys_clk(sys_clk),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData),
    .rdAddr(cpyIdx_r),
    .rdData(ramRdData)
  );

  // data flash image
  rics_cfg_mem uFlash (
    .sys_clk(sys_clk),
    .wrEn(flashWrEn),
    .wrAddr(cpyIdx_r),
    .wrData(ramRdData),
    .rdAddr(cpyIdx_r),
    .rdData(flashRdData)
  );
endmodule

// file: dv/rics_reset_init_asserts.sv
/* checker: reset hold, safe pins, init length, write and store timing.
   assumes the ports of rics_reset_init only. */
`timescale 1ns/100ps
`include "rics_regs.vh"
module rics_reset_init_asserts #(
  parameter [`RICS_CNT_W-1:0] INIT_CYC = 64
) (
  input wire sys_clk,
  input wire rst,
  input wire supplyOk,
  input wire extResetN,
  input wire cfgWrEn,
  input wire [`RICS_ADDR_W-1:0] cfgWrAddr,
  input wire [`RICS_DATA_W-1:0] cfgWrData,
  input wire cfgWrReady,
  input wire storeAllReq,
  input wire storeAllReady,
  input wire storeDone_r,
  input wire inReset_r,
  input wire initActive_r,
  input wire normalRun_r,
  input wire [`RICS_FAST_PINS-1:0] fastPulseOut_r,
  input wire [`RICS_FAST_PINS-1:0] fastPulseOe_r,
  input wire [`RICS_GPIO_PINS-1:0] gpioOe_r,
  input wire seqEnable_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg [`RICS_CNT_W-1:0] initCnt_r; // cycles spent in init so far
  wire wrTake = cfgWrEn && cfgWrReady; // host write accepted
  wire stTake = storeAllReq && storeAllReady; // store accepted
  // count init cycles so its length can be judged at its end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      initCnt_r <= 20'h0_0000;
    end else begin
      initCnt_r <= initActive_r ? initCnt_r + 20'h0_0001 : 20'h0_0000;
    end
  end
  property p_supHold; !supplyOk |-> ##[2:3] inReset_r; endproperty
  a_supHold: assert property (p_supHold) else $error("no reset on low supply");
  property p_pinHold; !extResetN |-> ##[2:3] inReset_r; endproperty
  a_pinHold: assert property (p_pinHold) else $error("no reset on low pin");
  property p_release; $rose(supplyOk && extResetN) |-> ##[2:4] !inReset_r; endproperty
  a_release: assert property (p_release) else $error("reset release late");
  property p_enterInit; $fell(inReset_r) |-> ##[0:1] initActive_r; endproperty
  a_enterInit: assert property (p_enterInit) else $error("no init after reset");
  property p_initLen;
    $fell(initActive_r) && normalRun_r |-> initCnt_r >= INIT_CYC - 1 && initCnt_r <= INIT_CYC + 1;
  endproperty
  a_initLen: assert property (p_initLen) else $error("init length wrong");
  property p_initSafe;
    initActive_r |-> fastPulseOut_r == 8'h00 && &fastPulseOe_r && gpioOe_r == 18'h0_0000;
  endproperty
  a_initSafe: assert property (p_initSafe) else $error("pins unsafe in init");
  property p_wrApply;
    wrTake && cfgWrAddr == `RICS_CFG_GPIO_OE |-> ##2 gpioOe_r == $past(cfgWrData, 2);
  endproperty
  a_wrApply: assert property (p_wrApply) else $error("write not applied");
  property p_ctrl;
    wrTake && cfgWrAddr == `RICS_CFG_CTRL |-> ##2 seqEnable_r == $past(cfgWrData[0], 2);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("sequencing mode wrong");
  property p_store; stTake |-> ##33 storeDone_r; endproperty
  a_store: assert property (p_store) else $error("store done late");
  property p_busy; stTake |=> !cfgWrReady [*8]; endproperty
  a_busy: assert property (p_busy) else $error("writes open during store");
  c_store: cover property (storeDone_r);
  c_init: cover property ($fell(initActive_r));
  c_write: cover property (wrTake);
endmodule
bind rics_reset_init rics_reset_init_asserts #(.INIT_CYC(INIT_CYC)) chk (.*);

// file: dv/rics_host_model.sv
/* host and reset source model: parameter writes, store-all, reset pin
   and supply detector; drives at the falling edge of sys_clk. */
`timescale 1ns/100ps
`include "rics_regs.vh"
module rics_host_model (
  input wire sys_clk,
  output reg supplyOk,
  output reg extResetN,
  output reg cfgWrEn,
  output reg [`RICS_ADDR_W-1:0] cfgWrAddr,
  output reg [`RICS_DATA_W-1:0] cfgWrData,
  output reg storeAllReq
);
  initial begin
    supplyOk = 1'b1;
    extResetN = 1'b1;
    cfgWrEn = 1'b0;
    cfgWrAddr = 4'h0;
    cfgWrData = 18'h0_0000;
    storeAllReq = 1'b0;
  end
  // one word per write; idle bus shows the inverse, never a stale word
  task wr(input [`RICS_ADDR_W-1:0] a, input [`RICS_DATA_W-1:0] d);
    begin
      @(negedge sys_clk);
      cfgWrEn = 1'b1;
      cfgWrAddr = a;
      cfgWrData = d;
      @(negedge sys_clk);
      cfgWrEn = 1'b0;
      cfgWrAddr = ~a;
      cfgWrData = ~d;
    end
  endtask
  // commit command, sent once all words are written
  task store;
    begin
      @(negedge sys_clk);
      storeAllReq = 1'b1;
      @(negedge sys_clk);
      storeAllReq = 1'b0;
    end
  endtask
  // reset pin held low n cycles, n above the minimum pulse
  task pinLow(input integer n);
    begin
      @(negedge sys_clk);
      extResetN = 1'b0;
      repeat (n) @(negedge sys_clk);
      extResetN = 1'b1;
    end
  endtask
endmodule

// file: dv/tb.sv
/* testbench of rics_reset_init: table of writes, then store, pin,
   supply and mid-run resets. assumes rics_host_model drives inputs. */
`timescale 1ns/100ps
`include "rics_regs.vh"
module tb;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  wire supplyOk, extResetN, cfgWrEn, storeAllReq, cfgWrReady, storeAllReady;
  wire storeDone_r, inReset_r, initActive_r, normalRun_r, seqEnable_r, faultRespEnable_r;
  wire [3:0] cfgWrAddr;
  wire [17:0] cfgWrData, gpioOut_r, gpioOe_r;
  wire [7:0] fastPulseOut_r, fastPulseOe_r;
  wire [53:0] obs = {gpioOe_r, gpioOut_r, fastPulseOut_r, fastPulseOe_r,
                     seqEnable_r, faultRespEnable_r}; // pins and modes
  integer num_errors = 0;
  integer n_compared = 0;
  integer i, n;
  reg [17:0] ram [0:3]; // expected working words 0..3
  reg [17:0] fl [0:3]; // expected flash words 0..3
  reg [3:0] rowA [0:4];
  reg [17:0] rowD [0:4];
  // expected pins and modes, built at call time from the modelled words
  function [53:0] expV();
    expV = {ram[0], ram[1], ram[3][7:0], 8'hFF, ram[2][0], ram[2][1]};
  endfunction
  always #12.5 sys_clk = ~sys_clk;
  rics_reset_init #(.INIT_CYC(20'h0_0040)) uut (.*);
  rics_host_model hm (.*);
  task chk(input [53:0] got, input [53:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        num_errors = num_errors + 1;
      end
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // wait for normal run, bounded; working words come back from flash
  task waitRun;
    begin
      n = 0;
      while (normalRun_r !== 1'b1 && n < 300) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      if (n == 300) begin
        num_errors = num_errors + 1;
        stop_test;
      end
      for (i = 0; i < 4; i = i + 1) ram[i] = fl[i];
    end
  endtask
  initial begin
    for (i = 0; i < 4; i = i + 1) fl[i] = 18'h0_0000;
    rowA[0] = 4'h0; rowD[0] = 18'h3_00A5;
    rowA[1] = 4'h1; rowD[1] = 18'h1_5A5A;
    rowA[2] = 4'h2; rowD[2] = 18'h0_0003;
    rowA[3] = 4'h3; rowD[3] = 18'h0_00C3;
    rowA[4] = 4'h4; rowD[4] = 18'h2_AAAA;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    waitRun;
    chk(obs, expV());
    for (i = 0; i < 5; i = i + 1) begin
      hm.wr(rowA[i], rowD[i]);
      repeat (3) @(negedge sys_clk);
      if (rowA[i] < 4) ram[rowA[i]] = rowD[i];
      chk(obs, expV());
    end
    $display("table of writes done");
    hm.store;
    n = 0;
    while (storeDone_r !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n = n + 1;
    end
    // 16 words, two cycles each: seen at the negedge after the last copy edge
    chk(n, 2 * `RICS_DEPTH);
    if (n == 60) stop_test;
    for (i = 0; i < 4; i = i + 1) fl[i] = ram[i];
    hm.wr(4'h0, 18'h0_0FFF);
    repeat (3) @(negedge sys_clk);
    ram[0] = 18'h0_0FFF;
    chk(obs, expV());
    $display("store done");
    hm.pinLow(4);
    n = 0;
    while (initActive_r !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n = n + 1;
    end
    chk(n > 4, 0);
    hm.wr(4'h0, 18'h0_0055);
    waitRun;
    chk(obs, expV());
    $display("pin reset done");
    @(negedge sys_clk);
    force_supply(1'b0);
    repeat (4) @(negedge sys_clk);
    chk({inReset_r, gpioOe_r}, 19'h4_0000);
    force_supply(1'b1);
    @(negedge sys_clk);
    waitRun;
    chk(obs, expV());
    $display("supply reset done");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    waitRun;
    chk(obs, expV());
    $display("mid-run reset done");
    stop_test;
  end
  task force_supply(input v);
    hm.supplyOk = v;
  endtask
endmodule
